// >>> pkg/htl_pkg.sv
// Package for the single-wire humidity/temperature link: timing counts,
// frame layout and state enumerations shared by both ends.
// Assumes a 50 MHz clock on both ends.
package htl_pkg;
    localparam int CLK_MHZ = 50;
    // Times in microseconds, as printed
    localparam int START_MIN_US = 1000;
    localparam int START_MAX_US = 20000;
    localparam int GO_MIN_US = 10;
    localparam int GO_MAX_US = 200;
    localparam int GO_TYP_US = 30;
    localparam int ACK_US = 80;
    localparam int LOW_US = 50;
    localparam int HIGH0_US = 26;
    localparam int HIGH1_US = 70;
    localparam int END_US = 50;
    localparam int GAP_US = 2000000;
    // Cycle counts derived from the clock rate
    localparam int START_MIN_CYC = START_MIN_US * CLK_MHZ;
    localparam int START_MAX_CYC = START_MAX_US * CLK_MHZ;
    localparam int GO_MIN_CYC = GO_MIN_US * CLK_MHZ;
    localparam int GO_MAX_CYC = GO_MAX_US * CLK_MHZ;
    localparam int GO_TYP_CYC = GO_TYP_US * CLK_MHZ;
    localparam int ACK_CYC = ACK_US * CLK_MHZ;
    localparam int LOW_CYC = LOW_US * CLK_MHZ;
    localparam int HIGH0_CYC = HIGH0_US * CLK_MHZ;
    localparam int HIGH1_CYC = HIGH1_US * CLK_MHZ;
    localparam int END_CYC = END_US * CLK_MHZ;
    localparam int GAP_CYC = GAP_US * CLK_MHZ;
    // Host decides a bit is one above this high time (midpoint)
    localparam int BIT_SPLIT_CYC = (HIGH0_CYC + HIGH1_CYC) / 2;
    // Host abandons an acknowledge or bit phase that lasts longer than this
    localparam int PHASE_TMO_CYC = 2 * ACK_CYC;
    // Frame layout
    localparam int FRAME_BITS = 40;
    localparam int TEMPERATURE_SIGN_BIT = 15;
    localparam int CNT_W = 32;
    localparam int BIT_W = 6;
    localparam logic [BIT_W-1:0] LAST_BIT = 6'h27;
    typedef enum logic [2:0] {
        SNS_IDLE, SNS_START, SNS_GO, SNS_ACKL, SNS_ACKH, SNS_BITL, SNS_BITH,
        SNS_END
    } htl_sns_state_type;
    typedef enum logic [2:0] {
        HST_IDLE, HST_START, HST_GO, HST_ACKL, HST_ACKH, HST_BITL, HST_BITH
    } htl_hst_state_type;
endpackage

// >>> pkg/htl_if.sv
// Interface carrying the open-drain data wire between host and sensor.
// Models the external pull-up: the line is low while either end pulls it.
`timescale 1ns/10ps
`default_nettype none
interface htl_if;
    logic host_oe;
    logic sns_oe;
    logic line;
    // Pull-up keeps the wire high unless someone pulls low
    assign line = ~(host_oe | sns_oe);
    modport host (output host_oe, input line);
    modport sensor (output sns_oe, input line);
endinterface
`default_nettype wire

// >>> rtl/htl_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module htl_fifo #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Fill side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // Drain side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    always_comb begin
        push = in_valid_in && (cnt_q != (AW+1)'(DEPTH));
        pop = (cnt_q != '0) && out_ready_in;
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        in_ready_out = cnt_q != (AW+1)'(DEPTH);
        out_valid_out = cnt_q != '0;
        out_data_out = mem[rd_q];
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
        if (push) begin
            mem[wr_q] <= in_data_in;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/htl_sensor.sv
// Sensor end of the single-wire humidity/temperature link.
// Assumes the line is synchronous to clk_in and pulled up outside.
//
// Contract
// - Host start pulse low at least 1 ms
// - Acknowledge: 80 us low, then 80 us high
// - Forty bits follow acknowledge, MSB first
// - Humidity word first, ten times percent
// - Temperature word next, ten times Celsius
// - Temperature sign-magnitude, top bit negative
// - Checksum is low byte of sum
// - Pull low or release, never drive high
// - Transmit only after valid host start
// - Bad host timing gives no reply; a start held low past START_MAX restarts the count and is answered if the low after the restart reaches START_MIN
// - Host spaces reads at least 2 s
// - Host waits 2 s after power-up
// - Frame carries previous measurement
// - Zero: 50 us low, 26 us high
// - One: 50 us low, 70 us high
// - After last bit: 50 us low, release
// - Host releases line 10-200 us before answer
`timescale 1ns/10ps
`default_nettype none
module htl_sensor
    import htl_pkg::*;
#(
    parameter int START_MIN = START_MIN_CYC,
    parameter int START_MAX = START_MAX_CYC,
    // Cycles per microsecond; a smaller value shortens every phase but the start pulse limits, set by START_MIN and START_MAX
    parameter int US_CYC = CLK_MHZ
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Measurement input, latched as the next frame's content
    input wire logic meas_valid_in,
    input wire logic [15:0] meas_humidity_in,
    input wire logic meas_negative_in,
    input wire logic [14:0] meas_temp_mag_in,
    // Status
    output logic busy_out,
    output logic frame_done_out,
    // Link
    htl_if.sensor link
);
    htl_sns_state_type st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [BIT_W-1:0] bit_q, bit_d;
    logic [FRAME_BITS-1:0] sh_q, sh_d;
    logic [FRAME_BITS-1:0] stored_q, stored_d;
    logic oe_q, oe_d;
    logic done_q, done_d;
    logic [15:0] temp_word;
    logic [7:0] csum;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        temp_word = {meas_negative_in, meas_temp_mag_in};
        csum = meas_humidity_in[15:8] + meas_humidity_in[7:0]
            + temp_word[15:8] + temp_word[7:0];
        // latest measurement is held for the next read
        stored_d = stored_q;
        if (meas_valid_in && st_q == SNS_IDLE) begin
            // humidity then temperature, high bytes first
            stored_d = {meas_humidity_in, temp_word, csum};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q + 1'b1;
        bit_d = bit_q;
        sh_d = sh_q;
        oe_d = 1'b0;
        done_d = 1'b0;
        case (st_q)
            // passive until the host pulls low
            SNS_IDLE: begin
                cnt_d = '0;
                if (!link.line) begin
                    st_d = SNS_START;
                    // The first low sample already counts toward the pulse
                    cnt_d = CNT_W'(1);
                end
            end
            SNS_START: begin
                if (link.line) begin
                    cnt_d = '0;
                    // too short a pulse is ignored
                    st_d = (cnt_q >= CNT_W'(START_MIN)) ? SNS_GO : SNS_IDLE;
                end else if (cnt_q > CNT_W'(START_MAX)) begin
                    st_d = SNS_IDLE;
                end
            end
            // wait the host release time, then answer
            SNS_GO: begin
                if (!link.line) begin
                    // host pulling again breaks the sequence
                    st_d = SNS_IDLE;
                end else if (cnt_q >= CNT_W'(GO_TYP_US * US_CYC - 1)) begin
                    st_d = SNS_ACKL;
                    cnt_d = '0;
                    sh_d = stored_q;
                    bit_d = '0;
                    oe_d = 1'b1;
                end
            end
            SNS_ACKL: begin
                oe_d = 1'b1;
                if (cnt_q == CNT_W'(ACK_US * US_CYC - 1)) begin
                    st_d = SNS_ACKH;
                    cnt_d = '0;
                    oe_d = 1'b0;
                end
            end
            SNS_ACKH: begin
                if (cnt_q == CNT_W'(ACK_US * US_CYC - 1)) begin
                    st_d = SNS_BITL;
                    cnt_d = '0;
                    oe_d = 1'b1;
                end
            end
            // common low phase of every bit
            SNS_BITL: begin
                oe_d = 1'b1;
                if (cnt_q == CNT_W'(LOW_US * US_CYC - 1)) begin
                    st_d = SNS_BITH;
                    cnt_d = '0;
                    oe_d = 1'b0;
                end
            end
            // MSB first; high length carries the bit
            SNS_BITH: begin
                if (cnt_q == CNT_W'((sh_q[FRAME_BITS-1] ? HIGH1_US : HIGH0_US)
                                    * US_CYC - 1)) begin
                    cnt_d = '0;
                    oe_d = 1'b1;
                    sh_d = {sh_q[FRAME_BITS-2:0], 1'b0};
                    bit_d = bit_q + 1'b1;
                    st_d = (bit_q == LAST_BIT) ? SNS_END : SNS_BITL;
                end
            end
            SNS_END: begin
                oe_d = 1'b1;
                if (cnt_q == CNT_W'(END_US * US_CYC - 1)) begin
                    st_d = SNS_IDLE;
                    oe_d = 1'b0;
                    done_d = 1'b1;
                end
            end
            default: begin
                st_d = SNS_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            st_q <= SNS_IDLE;
            cnt_q <= '0;
            bit_q <= '0;
            sh_q <= '0;
            stored_q <= '0;
            oe_q <= 1'b0;
            done_q <= 1'b0;
            busy_out <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            stored_q <= stored_d;
            oe_q <= oe_d;
            done_q <= done_d;
            busy_out <= st_d != SNS_IDLE;
        end
    end

    // the sensor only ever pulls low
    assign link.sns_oe = oe_q;
    assign frame_done_out = done_q;
endmodule
`default_nettype wire

// >>> rtl/htl_host.sv
// Host end of the single-wire link: issues a read on request, decodes
// the frame, checks it and queues good frames in a FIFO.
// Assumes the line is synchronous to clk_in and pulled up outside.
`timescale 1ns/10ps
`default_nettype none
module htl_host
    import htl_pkg::*;
#(
    parameter int START_LEN = START_MIN_CYC,
    parameter int GAP_LEN = GAP_CYC,
    // Cycles per microsecond; a smaller value shortens every phase but the start pulse and the read gap, set by START_LEN and GAP_LEN
    parameter int US_CYC = CLK_MHZ
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Read request
    input wire logic read_req_in,
    output logic ready_out,
    // Received frames
    output logic frame_valid_out,
    output logic [FRAME_BITS-1:0] frame_data_out,
    input wire logic frame_ready_in,
    // Errors
    output logic csum_err_out,
    output logic timeout_out,
    // Link
    htl_if.host link
);
    htl_hst_state_type st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d, gap_q, gap_d;
    logic [BIT_W-1:0] bit_q, bit_d;
    logic [FRAME_BITS-1:0] sh_q, sh_d;
    logic oe_q, oe_d, push_q, push_d, cerr_q, cerr_d, tmo_q, tmo_d;
    logic rdy_q, fifo_ready;
    logic [FRAME_BITS-1:0] nxt;
    logic [7:0] sum;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q + 1'b1;
        gap_d = (gap_q != '0) ? gap_q - 1'b1 : gap_q;
        bit_d = bit_q;
        sh_d = sh_q;
        oe_d = 1'b0;
        push_d = 1'b0;
        cerr_d = 1'b0;
        tmo_d = 1'b0;
        nxt = {sh_q[FRAME_BITS-2:0],
               cnt_q > CNT_W'((HIGH0_US + HIGH1_US) * US_CYC / 2)};
        sum = nxt[39:32] + nxt[31:24] + nxt[23:16] + nxt[15:8];
        case (st_q)
            // no start until the gap has run out
            HST_IDLE: begin
                cnt_d = '0;
                if (read_req_in && gap_q == '0 && fifo_ready) begin
                    st_d = HST_START;
                    oe_d = 1'b1;
                    gap_d = CNT_W'(GAP_LEN);
                end
            end
            HST_START: begin
                oe_d = 1'b1;
                if (cnt_q == CNT_W'(START_LEN - 1)) begin
                    oe_d = 1'b0;
                    cnt_d = '0;
                    st_d = HST_GO;
                end
            end
            HST_GO: begin
                if (!link.line && cnt_q >= CNT_W'(GO_MIN_US * US_CYC)) begin
                    cnt_d = '0;
                    st_d = HST_ACKL;
                end else if (cnt_q > CNT_W'(GO_MAX_US * US_CYC)) begin
                    tmo_d = 1'b1;
                    st_d = HST_IDLE;
                end
            end
            HST_ACKL, HST_ACKH, HST_BITL: begin
                if (link.line == (st_q != HST_ACKH)) begin
                    cnt_d = '0;
                    bit_d = '0;
                    st_d = (st_q == HST_ACKL) ? HST_ACKH :
                           (st_q == HST_ACKH) ? HST_BITL : HST_BITH;
                end else if (cnt_q > CNT_W'(2 * ACK_US * US_CYC)) begin
                    tmo_d = 1'b1;
                    st_d = HST_IDLE;
                end
                if (st_q == HST_BITL) begin
                    bit_d = bit_q;
                end
            end
            // Bit value from the length of the high phase
            HST_BITH: begin
                if (!link.line) begin
                    cnt_d = '0;
                    sh_d = nxt;
                    bit_d = bit_q + 1'b1;
                    st_d = HST_BITL;
                    if (bit_q == LAST_BIT) begin
                        st_d = HST_IDLE;
                        // keep only frames whose checksum matches
                        push_d = sum == nxt[7:0];
                        cerr_d = sum != nxt[7:0];
                    end
                end else if (cnt_q > CNT_W'(2 * ACK_US * US_CYC)) begin
                    tmo_d = 1'b1;
                    st_d = HST_IDLE;
                end
            end
            default: begin
                st_d = HST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            st_q <= HST_IDLE;
            cnt_q <= '0;
            // power-up wait counts as a gap
            gap_q <= CNT_W'(GAP_LEN);
            bit_q <= '0;
            sh_q <= '0;
            oe_q <= 1'b0;
            push_q <= 1'b0;
            cerr_q <= 1'b0;
            tmo_q <= 1'b0;
            rdy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            gap_q <= gap_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            oe_q <= oe_d;
            push_q <= push_d;
            cerr_q <= cerr_d;
            tmo_q <= tmo_d;
            rdy_q <= st_d == HST_IDLE && gap_d == '0 && fifo_ready;
        end
    end

    // Full FIFO holds off new reads, so a pushed frame is never dropped
    htl_fifo #(.WIDTH(FRAME_BITS), .DEPTH(16)) u_fifo (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .in_valid_in(push_q),
        .in_data_in(sh_q),
        .in_ready_out(fifo_ready),
        .out_valid_out(frame_valid_out),
        .out_data_out(frame_data_out),
        .out_ready_in(frame_ready_in)
    );

    assign link.host_oe = oe_q;
    assign ready_out = rdy_q;
    assign csum_err_out = cerr_q;
    assign timeout_out = tmo_q;
endmodule
`default_nettype wire

// >>> testbench/htl_link_props.sv
// Checker for the single-wire link between host and sensor ends.
// Assumes it watches the wire of an htl_if joining two design ends.
`timescale 1ns/10ps
`default_nettype none
module htl_link_props
    import htl_pkg::*;
#(
    parameter int START_LEN = 200,
    parameter int GAP_LEN = 1000,
    parameter int START_MIN = 200,
    parameter int US_CYC = CLK_MHZ
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Wire
    input wire logic host_oe,
    input wire logic sns_oe,
    input wire logic line
);
    logic [31:0] host_run_q, sns_run_q, hi_run_q, since_q, last_host_q;
    logic [5:0] pulses_q;
    localparam int GO_N = GO_TYP_US * US_CYC;
    localparam int ACK_N = ACK_US * US_CYC;
    localparam int LOW_N = LOW_US * US_CYC;
    localparam int HIGH0_N = HIGH0_US * US_CYC;
    localparam int HIGH1_N = HIGH1_US * US_CYC;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    ////////////////////////////////////////////////////////////////////////
    // Run lengths of each level, counted in sampled cycles
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            host_run_q <= '0;
            sns_run_q <= '0;
            hi_run_q <= '0;
            since_q <= '0;
            last_host_q <= '0;
            pulses_q <= '0;
        end else begin
            host_run_q <= host_oe ? host_run_q + 1 : '0;
            sns_run_q <= sns_oe ? sns_run_q + 1 : '0;
            hi_run_q <= line ? hi_run_q + 1 : '0;
            since_q <= (host_oe && host_run_q == 0) ? 32'h1 : since_q + 1;
            if (!host_oe && host_run_q != 0) begin
                last_host_q <= host_run_q;
            end
            if (host_oe) begin
                pulses_q <= '0;
            end else if (sns_oe && sns_run_q == 0) begin
                pulses_q <= pulses_q + 1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    host_start_a: assert property (
        $fell(host_oe) |-> host_run_q == START_LEN)
        else $error("host start pulse length wrong");
    read_gap_a: assert property (
        $rose(host_oe) |-> since_q >= GAP_LEN - 2)
        else $error("reads spaced too closely");
    // Sensor pulls: 80 us acknowledge or 50 us bit and closing lows
    sns_low_a: assert property (
        $fell(sns_oe) |-> sns_run_q inside {[ACK_N-1:ACK_N+1],
                                            [LOW_N-1:LOW_N+1]})
        else $error("sensor low phase length wrong");
    sns_high_a: assert property (
        $rose(sns_oe) |-> hi_run_q inside {[GO_N-1:GO_N+1],
            [ACK_N-1:ACK_N+1], [HIGH0_N-1:HIGH0_N+1],
            [HIGH1_N-1:HIGH1_N+1]})
        else $error("high phase before sensor pull wrong");
    // First sensor pull after host activity must follow a long enough start
    reply_start_a: assert property (
        $rose(sns_oe) && pulses_q == 6'd0 |-> last_host_q >= START_MIN)
        else $error("sensor replied without valid start");
    pulse_count_a: assert property (
        $rose(sns_oe) |-> pulses_q < 6'd42)
        else $error("sensor sent too many pulses");
    frame_whole_a: assert property (
        hi_run_q == 32'(4 * ACK_N) |-> pulses_q == 6'd0 || pulses_q == 6'd42)
        else $error("frame ended incomplete");
    no_clash_a: assert property (
        !(host_oe && sns_oe))
        else $error("both ends pull the wire");
endmodule
`default_nettype wire

// >>> testbench/htl_link_bench.sv
// Testbench joining host and sensor ends, plus a bench-driven host on a
// second wire for a lone sensor. Assumes the htl_pkg constants.
`timescale 1ns/10ps
`default_nettype none
module htl_link_bench;
    import htl_pkg::*;
    localparam int SLEN = 200;
    // One cycle per microsecond keeps a frame near 4k cycles
    localparam int US = 1;
    // Gap longer than a frame, so a read never meets the closing low
    localparam int GLEN = 4500;
    localparam int SPLIT = (HIGH0_US + HIGH1_US) * US / 2;
    localparam int GO_LO = GO_MIN_US * US;
    localparam int GO_HI = GO_MAX_US * US;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic rst2_n = 1'b0;
    logic read_req = 1'b0;
    logic frame_ready = 1'b0;
    logic meas_valid = 1'b0;
    logic [15:0] hum = 16'h0000;
    logic neg = 1'b0;
    logic [14:0] mag = 15'h0000;
    logic ready, fvalid, csum_err, tmo, busy, done;
    logic [FRAME_BITS-1:0] fdata;
    int err_pulses = 0;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    htl_if link1();
    htl_if link2();

    htl_sensor #(.START_MIN(SLEN), .US_CYC(US)) i_htl_sensor (
        .clk_in(clk_in), .rstn_in(rstn_in), .meas_valid_in(meas_valid),
        .meas_humidity_in(hum), .meas_negative_in(neg),
        .meas_temp_mag_in(mag), .busy_out(busy), .frame_done_out(done),
        .link(link1.sensor));
    htl_sensor #(.START_MIN(SLEN), .US_CYC(US)) i_htl_sensor_2 (
        .clk_in(clk_in), .rstn_in(rst2_n), .meas_valid_in(meas_valid),
        .meas_humidity_in(hum), .meas_negative_in(neg),
        .meas_temp_mag_in(mag), .busy_out(), .frame_done_out(),
        .link(link2.sensor));
    htl_host #(.START_LEN(SLEN), .GAP_LEN(GLEN), .US_CYC(US)) i_htl_host (
        .clk_in(clk_in), .rstn_in(rstn_in), .read_req_in(read_req),
        .ready_out(ready), .frame_valid_out(fvalid), .frame_data_out(fdata),
        .frame_ready_in(frame_ready), .csum_err_out(csum_err),
        .timeout_out(tmo), .link(link1.host));
    htl_link_props #(.START_LEN(SLEN), .GAP_LEN(GLEN), .START_MIN(SLEN),
        .US_CYC(US)) u_props (.clk_in(clk_in), .rstn_in(rstn_in),
        .host_oe(link1.host_oe), .sns_oe(link1.sns_oe), .line(link1.line));

    ////////////////////////////////////////////////////////////////////////
    initial forever #10 clk_in = ~clk_in;
    initial link2.host_oe = 1'b0;

    // Seventeen reads at one gap each come to about 76k cycles
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (tmo === 1'b1 || csum_err === 1'b1) begin
            err_pulses <= err_pulses + 1;
        end
        if (cyc == 100000) begin
            fail_count++;
            end_of_test();
        end
    end

    task automatic check(string what, logic [39:0] exp, logic [39:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_lvl(input logic lvl, output int n);
        n = 0;
        while (link1.line !== lvl && n < 20000) begin
            @(posedge clk_in);
            n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Host FIFO: sixteen frames fill it and the seventeenth read is held off
    task automatic test_fifo();
        int n, k;
        k = 0;
        repeat (17) begin
            n = 0;
            do begin
                @(posedge clk_in);
                n++;
            end while (ready !== 1'b1 && n < 5000);
            if (ready === 1'b1) begin
                hum <= 16'(k);
                meas_valid <= 1'b1;
                read_req <= 1'b1;
                @(posedge clk_in);
                meas_valid <= 1'b0;
                read_req <= 1'b0;
                k++;
            end
        end
        check("fifo fill count", 40'd16, 40'(k));
        frame_ready <= 1'b1;
        n = 0;
        repeat (24) begin
            @(posedge clk_in);
            if (fvalid === 1'b1) begin
                check("fifo data", 40'(n), 40'(fdata[39:24]));
                n++;
            end
        end
        frame_ready <= 1'b0;
        check("fifo drain count", 40'd16, 40'(n));
        check("error pulses", 40'd0, 40'(err_pulses));
        $display("fifo test done");
    endtask

    task automatic test_refuse();
        int n;
        rst2_n <= 1'b1;
        @(posedge clk_in);
        link2.host_oe <= 1'b1;
        repeat (SLEN - 50) @(posedge clk_in);
        link2.host_oe <= 1'b0;
        n = 0;
        repeat (500) begin
            @(posedge clk_in);
            if (link2.sns_oe === 1'b1) n++;
        end
        check("short start reply", 40'd0, 40'(n));
        link2.host_oe <= 1'b1;
        repeat (SLEN + 10) @(posedge clk_in);
        link2.host_oe <= 1'b0;
        n = 0;
        while (link2.sns_oe !== 1'b1 && n < 12000) begin
            @(posedge clk_in);
            n++;
        end
        check("reply time", 40'd1, 40'(n >= GO_LO && n <= GO_HI));
        check("wire low on pull", 40'd0, 40'(link2.line));
        n = 0;
        while (link2.sns_oe === 1'b1 && n < 9000) begin
            @(posedge clk_in);
            n++;
        end
        n = n - ACK_US * US;
        check("ack low length", 40'd1, 40'(n >= -2 && n <= 2));
        rst2_n <= 1'b0;
        $display("refusal test done");
    endtask

    task automatic test_frame();
        int n;
        logic [39:0] exp, w;
        hum <= 16'h0292;
        neg <= 1'b1;
        mag <= 15'h0065;
        meas_valid <= 1'b1;
        repeat (4) @(posedge clk_in);
        meas_valid <= 1'b0;
        exp = {16'h0292, 16'h8065, 8'h00};
        exp[7:0] = exp[39:32] + exp[31:24] + exp[23:16] + exp[15:8];
        n = 0;
        while (ready !== 1'b1 && n < 5000) begin
            @(posedge clk_in);
            n++;
        end
        read_req <= 1'b1;
        @(posedge clk_in);
        read_req <= 1'b0;
        wait_lvl(1'b0, n);
        wait_lvl(1'b1, n);
        wait_lvl(1'b0, n);
        check("sensor busy", 40'd1, 40'(busy));
        wait_lvl(1'b1, n);
        wait_lvl(1'b0, n);
        w = '0;
        for (int i = 0; i < FRAME_BITS; i++) begin
            wait_lvl(1'b1, n);
            wait_lvl(1'b0, n);
            w = {w[38:0], n > SPLIT};
        end
        wait_lvl(1'b1, n);
        check("frame done", 40'd1, 40'(done));
        n = n - END_US * US;
        check("closing low", 40'd1, 40'(n >= -2 && n <= 2));
        check("wire frame", exp, w);
        n = 0;
        while (fvalid !== 1'b1 && n < 100) begin
            @(posedge clk_in);
            n++;
        end
        check("host frame", exp, fdata);
        frame_ready <= 1'b1;
        @(posedge clk_in);
        frame_ready <= 1'b0;
        @(posedge clk_in);
        check("frame drained", 40'd0, 40'(fvalid));
        $display("frame test done");
    endtask

    task automatic end_of_test();
        $display("checked %0d failed %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk_in);
        rstn_in <= 1'b1;
        test_refuse();
        test_frame();
        test_fifo();
        end_of_test();
    end
endmodule
`default_nettype wire
